// ---- rtl/irqp.sv ----
// Shared constants and carriers for the interrupt enable masking block
package irqp;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EXT_EN_ADDR   = 8'h9B;
  localparam logic [7:0] EXT_TWO_ADDR  = 8'h9C;
  localparam logic [7:0] MAIN_EN_ADDR  = 8'hA8;
  localparam logic [7:0] MAIN_BIT_BASE = 8'hA8;
  localparam logic [7:0] EN_RESET      = 8'h00;
  localparam logic [7:0] EXT_TWO_MASK  = 8'h07;
  localparam logic [7:0] UNMAPPED_RD   = 8'h00;

  // ----------------------------------------------------------------
  // Main enable fields
  // ----------------------------------------------------------------
  localparam int GATE_BIT = 7;
  localparam int ADC_BIT  = 6;
  localparam int BOD_BIT  = 5;
  localparam int UART0_BIT = 4;
  localparam int TMR1_BIT = 3;
  localparam int EXT1_BIT = 2;
  localparam int TMR0_BIT = 1;
  localparam int EXT0_BIT = 0;

  // ----------------------------------------------------------------
  // Extended and second extended enable fields
  // ----------------------------------------------------------------
  localparam int TMR2_BIT  = 7;
  localparam int SPI_BIT   = 6;
  localparam int BRAKE_BIT = 5;
  localparam int WDT_BIT   = 4;
  localparam int PWM_BIT   = 3;
  localparam int CAP_BIT   = 2;
  localparam int PIN_BIT   = 1;
  localparam int I2C_BIT   = 0;
  localparam int WKT_BIT   = 2;
  localparam int TMR3_BIT  = 1;
  localparam int UART1_BIT = 0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [7:0] bit_addr;
    logic       bit_val;
  } sfr_bus_s;

  typedef struct packed {
    logic       conv_done_flag;
    logic       brownout_flag;
    logic       uart0_tx_done;
    logic       uart0_rx_done;
    logic       tmr1_ovf_flag;
    logic       tmr0_ovf_flag;
    logic       tmr2_ovf_flag;
    logic       spi_done_flag;
    logic       spi_overrun_flag;
    logic       mode_fault_flag;
    logic       brake_flag;
    logic       wdt_timeout_flag;
    logic       pwm_period_flag;
    logic [2:0] capture_flags;
    logic [7:0] pin_flag_reg;
    logic       i2c_event_flag;
    logic       i2c_timeout_flag;
    logic       wakeup_tmr_flag;
    logic       tmr3_ovf_flag;
    logic       uart1_tx_done;
    logic       uart1_rx_done;
  } src_flags_s;

  typedef struct packed {
    logic adc;
    logic brownout;
    logic uart0;
    logic tmr1;
    logic ext1;
    logic tmr0;
    logic ext0;
    logic tmr2;
    logic spi;
    logic brake;
    logic wdt;
    logic pwm;
    logic capture;
    logic pinint;
    logic i2c;
    logic wakeup_tmr;
    logic tmr3;
    logic uart1;
  } irq_req_s;

endpackage

// ---- rtl/ext_irq_detect.sv ----
// External interrupt pin synchroniser with edge and level request flag
module ext_irq_detect (
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  input  wire logic pin_in,
  input  wire logic edge_mode_in,
  input  wire logic service_in,
  output logic      req_flag_out
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic flag_r;
  logic flag_nxt;
  wire  fall = prev_r & ~sync2_r;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Idle high so that release from reset with the pin high never fakes a falling edge
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r  <= 1'b1;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------------------------------
  // Request flag
  // ----------------------------------------------------------------
  always_comb begin
    flag_nxt = flag_r;
    if (!edge_mode_in) begin
      flag_nxt = ~sync2_r;
    end else if (fall) begin
      flag_nxt = 1'b1;
    end else if (service_in) begin
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign req_flag_out = flag_r;

  default clocking dcb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  edge_set_a: assert property (edge_mode_in && fall |=> flag_r)
    else $error("falling edge did not set flag");
  svc_clear_a: assert property (edge_mode_in && service_in && !fall |=> !flag_r)
    else $error("service entry did not clear flag");
  level_follow_a: assert property (!edge_mode_in |=> flag_r == !$past(sync2_r))
    else $error("level flag does not follow pin");

endmodule

// ---- rtl/interrupt_enable_masking.sv ----
// Interrupt enable registers and gating of source flags into CPU requests
//
// How it works
// - Global gate bit 7 of main enable blocks all sources when clear.
// - Main bit 6 gates the ADC conversion-done flag.
// - Main bit 5 gates the brown-out flag.
// - Main bit 4 gates serial port 0 transmit-done or receive-done.
// - Main bit 3 gates the timer 1 overflow flag.
// - Main bit 2 gates the external pin 1 request.
// - Main bit 1 gates the timer 0 overflow flag.
// - Main bit 0 gates the external pin 0 request.
// - Extended bit 7 gates the timer 2 overflow flag.
// - Extended bit 6 gates SPI done, overrun or mode fault.
// - Extended bit 5 gates the fault brake flag.
// - Extended bit 4 gates the watchdog flag.
// - Extended bit 3 gates the PWM period flag.
// - Extended bit 2 gates any of three capture flags.
// - Extended bit 1 gates any pin interrupt flag.
// - Extended bit 0 gates I2C bus event or timeout.
// - Second extended bit 2 gates the wake-up timer flag.
// - Second extended bit 1 gates the timer 3 overflow flag.
// - Second extended bit 0 gates serial port 1 transmit or receive.
// - Main enable is decoded on every page and takes single-bit writes.
// - Edge mode samples each clock and sets the flag on high then low.
// - Edge mode flag clears when the CPU enters that service routine.
// - Level mode flag is the inverted pin and is not cleared by service.
module interrupt_enable_masking (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire irqp::sfr_bus_s bus_in,
  input  wire irqp::src_flags_s flags_in,
  input  wire logic        ext0_pin_in,
  input  wire logic        ext1_pin_in,
  input  wire logic        ext0_edge_mode_in,
  input  wire logic        ext1_edge_mode_in,
  input  wire logic        ext0_service_in,
  input  wire logic        ext1_service_in,
  output logic [7:0]       rd_data_out,
  output irqp::irq_req_s   irq_req_out,
  output logic             ext0_req_flag_out,
  output logic             ext1_req_flag_out
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic addr_hit(
    input logic [7:0] a,
    input logic [7:0] t
  );
    return a == t;
  endfunction

  logic [7:0]     main_r;
  logic [7:0]     main_nxt;
  logic [7:0]     ext_r;
  logic [7:0]     ext_nxt;
  logic [7:0]     ext_two_r;
  logic [7:0]     ext_two_nxt;
  logic [7:0]     rd_data_r;
  logic [7:0]     rd_sel;
  irqp::irq_req_s req_r;
  irqp::irq_req_s req_nxt;
  logic [1:0]     pin_vec;
  logic [1:0]     mode_vec;
  logic [1:0]     svc_vec;
  logic [1:0]     ext_flag;

  // Page select is not decoded at all, so every page reaches these
  wire main_byte_wr = bus_in.wr_en
                    && addr_hit(bus_in.addr, irqp::MAIN_EN_ADDR);
  wire ext_wr       = bus_in.wr_en
                    && addr_hit(bus_in.addr, irqp::EXT_EN_ADDR);
  wire ext_two_wr   = bus_in.wr_en
                    && addr_hit(bus_in.addr, irqp::EXT_TWO_ADDR);
  wire main_bit_wr  = bus_in.bit_wr
                    && (bus_in.bit_addr[7:3] == irqp::MAIN_BIT_BASE[7:3]);
  wire main_rd      = addr_hit(bus_in.addr, irqp::MAIN_EN_ADDR);
  wire ext_rd       = addr_hit(bus_in.addr, irqp::EXT_EN_ADDR);
  wire ext_two_rd   = addr_hit(bus_in.addr, irqp::EXT_TWO_ADDR);

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  // A byte write wins over a bit write in the same cycle
  always_comb begin
    main_nxt = main_r;
    if (main_byte_wr) begin
      main_nxt = bus_in.wdata;
    end else if (main_bit_wr) begin
      main_nxt[bus_in.bit_addr[2:0]] = bus_in.bit_val;
    end
  end

  assign ext_nxt     = ext_wr ? bus_in.wdata : ext_r;
  assign ext_two_nxt = ext_two_wr ? (bus_in.wdata & irqp::EXT_TWO_MASK)
                                  : ext_two_r;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      main_r    <= irqp::EN_RESET;
      ext_r     <= irqp::EN_RESET;
      ext_two_r <= irqp::EN_RESET;
    end else begin
      main_r    <= main_nxt;
      ext_r     <= ext_nxt;
      ext_two_r <= ext_two_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign rd_sel = main_rd    ? main_r :
                  ext_rd     ? ext_r :
                  ext_two_rd ? ext_two_r :
                  irqp::UNMAPPED_RD;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_r <= irqp::UNMAPPED_RD;
    end else if (bus_in.rd_en) begin
      rd_data_r <= rd_sel;
    end
  end

  assign rd_data_out = rd_data_r;

  // ----------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------
  assign pin_vec  = {ext1_pin_in, ext0_pin_in};
  assign mode_vec = {ext1_edge_mode_in, ext0_edge_mode_in};
  assign svc_vec  = {ext1_service_in, ext0_service_in};

  for (genvar i = 0; i < 2; i++) begin : g_ext
    ext_irq_detect u_det (
      .mclk_in      (mclk_in),
      .rstn_in      (rstn_in),
      .pin_in       (pin_vec[i]),
      .edge_mode_in (mode_vec[i]),
      .service_in   (svc_vec[i]),
      .req_flag_out (ext_flag[i])
    );
  end

  assign ext0_req_flag_out = ext_flag[0];
  assign ext1_req_flag_out = ext_flag[1];

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  // Flags are only read here, so enables never alter them
  wire gate = main_r[irqp::GATE_BIT];

  wire uart0_any = flags_in.uart0_tx_done | flags_in.uart0_rx_done;
  wire spi_any   = flags_in.spi_done_flag | flags_in.spi_overrun_flag
                 | flags_in.mode_fault_flag;
  wire cap_any   = |flags_in.capture_flags;
  wire pin_any   = |flags_in.pin_flag_reg;
  wire i2c_any   = flags_in.i2c_event_flag | flags_in.i2c_timeout_flag;
  wire uart1_any = flags_in.uart1_tx_done | flags_in.uart1_rx_done;

  assign req_nxt.adc = gate & main_r[irqp::ADC_BIT]
                     & flags_in.conv_done_flag;
  assign req_nxt.brownout = gate & main_r[irqp::BOD_BIT]
                          & flags_in.brownout_flag;
  assign req_nxt.uart0 = gate & main_r[irqp::UART0_BIT]
                       & uart0_any;
  assign req_nxt.tmr1 = gate & main_r[irqp::TMR1_BIT]
                      & flags_in.tmr1_ovf_flag;
  assign req_nxt.ext1 = gate & main_r[irqp::EXT1_BIT]
                      & ext_flag[1];
  assign req_nxt.tmr0 = gate & main_r[irqp::TMR0_BIT]
                      & flags_in.tmr0_ovf_flag;
  assign req_nxt.ext0 = gate & main_r[irqp::EXT0_BIT]
                      & ext_flag[0];
  assign req_nxt.tmr2 = gate & ext_r[irqp::TMR2_BIT]
                      & flags_in.tmr2_ovf_flag;
  assign req_nxt.spi = gate & ext_r[irqp::SPI_BIT]
                     & spi_any;
  assign req_nxt.brake = gate & ext_r[irqp::BRAKE_BIT]
                       & flags_in.brake_flag;
  assign req_nxt.wdt = gate & ext_r[irqp::WDT_BIT]
                     & flags_in.wdt_timeout_flag;
  assign req_nxt.pwm = gate & ext_r[irqp::PWM_BIT]
                     & flags_in.pwm_period_flag;
  assign req_nxt.capture = gate & ext_r[irqp::CAP_BIT]
                         & cap_any;
  assign req_nxt.pinint = gate & ext_r[irqp::PIN_BIT]
                        & pin_any;
  assign req_nxt.i2c = gate & ext_r[irqp::I2C_BIT]
                     & i2c_any;
  assign req_nxt.wakeup_tmr = gate & ext_two_r[irqp::WKT_BIT]
                            & flags_in.wakeup_tmr_flag;
  assign req_nxt.tmr3 = gate & ext_two_r[irqp::TMR3_BIT]
                      & flags_in.tmr3_ovf_flag;
  assign req_nxt.uart1 = gate & ext_two_r[irqp::UART1_BIT]
                       & uart1_any;

  // Registered once so every request leaves from a flip-flop
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  assign irq_req_out = req_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence main_byte_s;
    main_byte_wr;
  endsequence

  sequence main_bit_s;
    main_bit_wr && !main_byte_wr;
  endsequence

  // Gate, own enable and flag all high in the same cycle
  sequence open_s(en, flg);
    gate && en && flg;
  endsequence

  gate_off_a: assert property (!gate |=> req_r == '0)
    else $error("request passed a closed gate");

  adc_pass_a: assert property (
    gate && main_r[irqp::ADC_BIT] && flags_in.conv_done_flag
    |=> req_r.adc)
    else $error("adc request missing");

  bod_block_a: assert property (
    !main_r[irqp::BOD_BIT] |=> !req_r.brownout)
    else $error("brown-out request not blocked");

  uart0_or_a: assert property (
    gate && main_r[irqp::UART0_BIT] && flags_in.uart0_rx_done
    |=> req_r.uart0)
    else $error("uart0 receive request missing");

  ext0_gate_a: assert property (
    req_r.ext0 |-> $past(ext_flag[0]) && $past(main_r[irqp::EXT0_BIT])
                   && $past(gate))
    else $error("ext0 request without cause");

  spi_or_a: assert property (
    gate && ext_r[irqp::SPI_BIT] && flags_in.mode_fault_flag
    |=> req_r.spi)
    else $error("spi mode fault request missing");

  cap_any_a: assert property (
    open_s(ext_r[irqp::CAP_BIT], flags_in.capture_flags[1]) |=> req_r.capture)
    else $error("capture request mismatch");

  pin_any_a: assert property (
    gate && ext_r[irqp::PIN_BIT] && flags_in.pin_flag_reg[7]
    |=> req_r.pinint)
    else $error("pin interrupt request missing");

  uart1_pass_a: assert property (
    gate && ext_two_r[irqp::UART1_BIT] && flags_in.uart1_tx_done
    |=> req_r.uart1)
    else $error("uart1 request missing");

  uart0_tx_a: assert property (
    open_s(main_r[irqp::UART0_BIT], flags_in.uart0_tx_done) |=> req_r.uart0)
    else $error("uart0 transmit request missing");

  tmr1_pass_a: assert property (
    open_s(main_r[irqp::TMR1_BIT], flags_in.tmr1_ovf_flag) |=> req_r.tmr1)
    else $error("timer 1 request missing");

  ext1_pass_a: assert property (
    open_s(main_r[irqp::EXT1_BIT], ext_flag[1]) |=> req_r.ext1)
    else $error("ext1 request missing");

  tmr0_pass_a: assert property (
    open_s(main_r[irqp::TMR0_BIT], flags_in.tmr0_ovf_flag) |=> req_r.tmr0)
    else $error("timer 0 request missing");

  ext0_pass_a: assert property (
    open_s(main_r[irqp::EXT0_BIT], ext_flag[0]) |=> req_r.ext0)
    else $error("ext0 request missing");

  tmr2_pass_a: assert property (
    open_s(ext_r[irqp::TMR2_BIT], flags_in.tmr2_ovf_flag) |=> req_r.tmr2)
    else $error("timer 2 request missing");

  spi_done_a: assert property (
    open_s(ext_r[irqp::SPI_BIT], flags_in.spi_done_flag) |=> req_r.spi)
    else $error("spi done request missing");

  brake_pass_a: assert property (
    open_s(ext_r[irqp::BRAKE_BIT], flags_in.brake_flag) |=> req_r.brake)
    else $error("brake request missing");

  wdt_pass_a: assert property (
    open_s(ext_r[irqp::WDT_BIT], flags_in.wdt_timeout_flag) |=> req_r.wdt)
    else $error("watchdog request missing");

  pwm_pass_a: assert property (
    open_s(ext_r[irqp::PWM_BIT], flags_in.pwm_period_flag) |=> req_r.pwm)
    else $error("pwm request missing");

  i2c_tout_a: assert property (
    open_s(ext_r[irqp::I2C_BIT], flags_in.i2c_timeout_flag) |=> req_r.i2c)
    else $error("i2c timeout request missing");

  i2c_event_a: assert property (
    open_s(ext_r[irqp::I2C_BIT], flags_in.i2c_event_flag) |=> req_r.i2c)
    else $error("i2c event request missing");

  wkt_pass_a: assert property (
    open_s(ext_two_r[irqp::WKT_BIT], flags_in.wakeup_tmr_flag) |=> req_r.wakeup_tmr)
    else $error("wake-up timer request missing");

  tmr3_pass_a: assert property (
    open_s(ext_two_r[irqp::TMR3_BIT], flags_in.tmr3_ovf_flag) |=> req_r.tmr3)
    else $error("timer 3 request missing");

  main_byte_a: assert property (
    main_byte_s |=> main_r == $past(bus_in.wdata))
    else $error("main enable byte write lost");

  main_bit_a: assert property (
    main_bit_s |=> main_r[$past(bus_in.bit_addr[2:0])]
                   == $past(bus_in.bit_val))
    else $error("main enable bit write lost");

  two_rsvd_a: assert property (
    (ext_two_r & ~irqp::EXT_TWO_MASK) == 8'h00)
    else $error("reserved bits of second extended enable set");

  rd_ans_a: assert property (
    bus_in.rd_en && main_rd && !main_byte_wr && !main_bit_wr
    ##1 1'b1 |-> rd_data_r == main_r)
    else $error("main enable readback wrong");

endmodule

// ---- bench/cpu_model.sv ----
// Behavioural CPU core and peripheral flag sources beside the enable block
module cpu_model (
  input  wire logic             mclk_in,
  input  wire irqp::src_flags_s flags_cmd_in,
  input  wire logic             pin0_cmd_in,
  input  wire logic             pin1_cmd_in,
  input  wire logic             enter0_in,
  input  wire logic             enter1_in,
  input  wire irqp::irq_req_s   irq_req_in,
  output irqp::src_flags_s      flags_out,
  output logic                  pin0_out,
  output logic                  pin1_out,
  output logic                  service0_out,
  output logic                  service1_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic taken0_r;
  logic taken1_r;

  initial begin
    flags_out = '0;
    pin0_out = 1'b1;
    pin1_out = 1'b1;
    service0_out = 1'b0;
    service1_out = 1'b0;
    taken0_r = 1'b0;
    taken1_r = 1'b0;
  end

  // Everything moves just after the falling edge, clear of the sampling edge
  // The core enters a routine once per command, and only on a pending request
  always @(negedge mclk_in) begin
    flags_out <= flags_cmd_in;
    pin0_out <= pin0_cmd_in;
    pin1_out <= pin1_cmd_in;
    service0_out <= enter0_in && irq_req_in.ext0 && !taken0_r;
    taken0_r <= enter0_in && (taken0_r || irq_req_in.ext0);
    service1_out <= enter1_in && irq_req_in.ext1 && !taken1_r;
    taken1_r <= enter1_in && (taken1_r || irq_req_in.ext1);
  end
endmodule

// ---- bench/test_interrupt_enable_masking.sv ----
// Self-checking bench for the interrupt enable masking block
module test_interrupt_enable_masking;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [23:0] en;
    logic [4:0]  fidx;
    logic [17:0] exp_req;
  } row_s;

  logic             mclk;
  logic             rstn;
  irqp::sfr_bus_s   bus;
  irqp::src_flags_s flags_cmd;
  irqp::src_flags_s flags;
  irqp::irq_req_s   irq_req;
  logic [7:0]       rd_data;
  logic [7:0]       d;
  logic             pin0_cmd, pin1_cmd, pin0, pin1;
  logic             enter0, enter1, svc0, svc1;
  logic             edge0, edge1, xf0, xf1;
  int               n_errors;
  int               compares;
  row_s             r;

  // Enables {main, ext, ext_two}, one-hot flag index (1f means all), requests
  row_s rows [42] = '{
    {24'hff_ff07,5'h1f,18'h3_d7ff}, {24'h7f_ff07,5'h1f,18'h0_0000}, {24'hc0_0000,5'h1f,18'h2_0000},
    {24'ha0_0000,5'h1f,18'h1_0000}, {24'h90_0000,5'h1f,18'h0_8000}, {24'h88_0000,5'h1f,18'h0_4000},
    {24'h82_0000,5'h1f,18'h0_1000}, {24'h80_8000,5'h1f,18'h0_0400}, {24'h80_4000,5'h1f,18'h0_0200},
    {24'h80_2000,5'h1f,18'h0_0100}, {24'h80_1000,5'h1f,18'h0_0080}, {24'h80_0800,5'h1f,18'h0_0040},
    {24'h80_0400,5'h1f,18'h0_0020}, {24'h80_0200,5'h1f,18'h0_0010}, {24'h80_0100,5'h1f,18'h0_0008},
    {24'h80_0004,5'h1f,18'h0_0004}, {24'h80_0002,5'h1f,18'h0_0002}, {24'h80_0001,5'h1f,18'h0_0001},
    {24'hff_bf07,5'h16,18'h0_0000}, {24'hff_ff07,5'h1d,18'h2_0000}, {24'hff_ff07,5'h1c,18'h1_0000},
    {24'hff_ff07,5'h1b,18'h0_8000}, {24'hff_ff07,5'h1a,18'h0_8000}, {24'hff_ff07,5'h19,18'h0_4000},
    {24'hff_ff07,5'h18,18'h0_1000}, {24'hff_ff07,5'h17,18'h0_0400}, {24'hff_ff07,5'h16,18'h0_0200},
    {24'hff_ff07,5'h15,18'h0_0200}, {24'hff_ff07,5'h14,18'h0_0200}, {24'hff_ff07,5'h13,18'h0_0100},
    {24'hff_ff07,5'h12,18'h0_0080}, {24'hff_ff07,5'h11,18'h0_0040}, {24'hff_ff07,5'h10,18'h0_0020},
    {24'hff_ff07,5'h0e,18'h0_0020}, {24'hff_ff07,5'h0d,18'h0_0010}, {24'hff_ff07,5'h06,18'h0_0010},
    {24'hff_ff07,5'h05,18'h0_0008}, {24'hff_ff07,5'h04,18'h0_0008}, {24'hff_ff07,5'h03,18'h0_0004},
    {24'hff_ff07,5'h02,18'h0_0002}, {24'hff_ff07,5'h01,18'h0_0001}, {24'hff_ff07,5'h00,18'h0_0001}};

  interrupt_enable_masking i_interrupt_enable_masking (
    .mclk_in           (mclk),
    .rstn_in           (rstn),
    .bus_in            (bus),
    .flags_in          (flags),
    .ext0_pin_in       (pin0),
    .ext1_pin_in       (pin1),
    .ext0_edge_mode_in (edge0),
    .ext1_edge_mode_in (edge1),
    .ext0_service_in   (svc0),
    .ext1_service_in   (svc1),
    .rd_data_out       (rd_data),
    .irq_req_out       (irq_req),
    .ext0_req_flag_out (xf0),
    .ext1_req_flag_out (xf1)
  );

  cpu_model i_cpu_model (
    .mclk_in      (mclk),
    .flags_cmd_in (flags_cmd),
    .pin0_cmd_in  (pin0_cmd),
    .pin1_cmd_in  (pin1_cmd),
    .enter0_in    (enter0),
    .enter1_in    (enter1),
    .irq_req_in   (irq_req),
    .flags_out    (flags),
    .pin0_out     (pin0),
    .pin1_out     (pin1),
    .service0_out (svc0),
    .service1_out (svc1)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic bus_cycle(input irqp::sfr_bus_s b);
    @(negedge mclk);
    bus = b;
    @(negedge mclk);
    bus = '0;
  endtask

  task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
    bus_cycle({2'h2, a, v, 10'h000});
  endtask

  task automatic wr_bit(input logic [7:0] a, input logic v);
    bus_cycle({18'h0_0000, 1'b1, a, v});
  endtask

  task automatic rd_byte(input logic [7:0] a, output logic [7:0] v);
    bus_cycle({2'h1, a, 18'h0_0000});
    v = rd_data;
  endtask

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_req(input string nm, input irqp::irq_req_s e, input irqp::irq_req_s g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic do_reset();
    @(negedge mclk);
    rstn = 1'b0;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
  endtask

  task automatic check_cleared();
    rd_byte(irqp::MAIN_EN_ADDR, d);
    cmp8("main_irq_enable", 8'h00, d);
    rd_byte(irqp::EXT_EN_ADDR, d);
    cmp8("extended_irq_enable", 8'h00, d);
    rd_byte(irqp::EXT_TWO_ADDR, d);
    cmp8("extended_irq_enable_two", 8'h00, d);
    cmp_req("irq_req_out", 18'h0_0000, irq_req);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, bus, flags_cmd, enter0, enter1, edge0, edge1} = '0;
    {pin0_cmd, pin1_cmd} = 2'h3;
    {n_errors, compares} = '0;
    do_reset();
    check_cleared();
    foreach (rows[i]) begin
      r = rows[i];
      wr_byte(irqp::MAIN_EN_ADDR, r.en[23:16]);
      wr_byte(irqp::EXT_EN_ADDR, r.en[15:8]);
      wr_byte(irqp::EXT_TWO_ADDR, r.en[7:0]);
      flags_cmd <= (r.fidx == 5'h1f) ? '1 : (30'h1 << r.fidx);
      repeat (3) @(negedge mclk);
      cmp_req("irq_req_out", r.exp_req, irq_req); // to
      rd_byte(irqp::MAIN_EN_ADDR, d);
      cmp8("main_irq_enable", r.en[23:16], d);
    end
    flags_cmd <= '0;
    wr_byte(irqp::EXT_TWO_ADDR, 8'hff);
    rd_byte(irqp::EXT_TWO_ADDR, d);
    cmp8("extended_irq_enable_two", 8'h07, d);
    rd_byte(8'h9d, d);
    cmp8("unmapped_read", 8'h00, d);
    wr_byte(irqp::MAIN_EN_ADDR, 8'h00);
    wr_byte(8'hb8, 8'hff);
    wr_bit(irqp::MAIN_BIT_BASE + 8'h07, 1'b1);
    wr_bit(irqp::MAIN_BIT_BASE + 8'h02, 1'b1);
    wr_bit(8'hb0, 1'b1);
    rd_byte(irqp::MAIN_EN_ADDR, d);
    cmp8("main_bit_set", 8'h84, d);
    wr_bit(irqp::MAIN_BIT_BASE + 8'h07, 1'b0);
    rd_byte(irqp::MAIN_EN_ADDR, d);
    cmp8("main_bit_clear", 8'h04, d);
    bus_cycle({2'h2, irqp::MAIN_EN_ADDR, 8'h10, 1'b1, irqp::MAIN_BIT_BASE + 8'h01, 1'b1});
    rd_byte(irqp::MAIN_EN_ADDR, d);
    cmp8("main_byte_over_bit", 8'h10, d);
    // One cycle from flag to request, one from gate clear to silence
    wr_byte(irqp::MAIN_EN_ADDR, 8'hc0);
    flags_cmd <= 30'h2000_0000;
    @(negedge mclk);
    cmp_req("irq_req_before", 18'h0_0000, irq_req);
    @(negedge mclk);
    cmp_req("irq_req_adc", 18'h2_0000, irq_req);
    wr_bit(irqp::MAIN_BIT_BASE + 8'h07, 1'b0);
    @(negedge mclk);
    cmp_req("irq_req_gated", 18'h0_0000, irq_req);
    flags_cmd <= '0;
    // Edge mode on pin 0
    wr_byte(irqp::MAIN_EN_ADDR, 8'h85);
    edge0 = 1'b1;
    pin0_cmd <= 1'b0;
    for (int k = 0; k < 8 && xf0 !== 1'b1; k++) @(negedge mclk);
    cmp_bit("ext0_req_flag", 1'b1, xf0);
    @(negedge mclk);
    cmp_req("irq_req_ext0", 18'h0_0800, irq_req);
    wr_byte(irqp::MAIN_EN_ADDR, 8'h00);
    repeat (2) @(negedge mclk);
    cmp_bit("ext0_flag_kept", 1'b1, xf0);
    cmp_req("irq_req_off", 18'h0_0000, irq_req);
    wr_byte(irqp::MAIN_EN_ADDR, 8'h85);
    enter0 <= 1'b1;
    repeat (8) @(negedge mclk);
    cmp_bit("ext0_flag_served", 1'b0, xf0);
    enter0 <= 1'b0;
    // Level mode on pin 1
    pin1_cmd <= 1'b0;
    for (int k = 0; k < 8 && xf1 !== 1'b1; k++) @(negedge mclk);
    cmp_bit("ext1_req_flag", 1'b1, xf1);
    @(negedge mclk);
    cmp_req("irq_req_ext1", 18'h0_2000, irq_req);
    enter1 <= 1'b1;
    repeat (6) @(negedge mclk);
    cmp_bit("ext1_flag_held", 1'b1, xf1);
    enter1 <= 1'b0;
    pin1_cmd <= 1'b1;
    repeat (6) @(negedge mclk);
    cmp_bit("ext1_flag_follow", 1'b0, xf1);
    // A second fall on pin 0 sets the flag again
    pin0_cmd <= 1'b1;
    repeat (6) @(negedge mclk);
    pin0_cmd <= 1'b0;
    for (int k = 0; k < 8 && xf0 !== 1'b1; k++) @(negedge mclk);
    cmp_bit("ext0_flag_again", 1'b1, xf0);
    pin0_cmd <= 1'b1;
    // Reset in mid-run clears every enable
    wr_byte(irqp::EXT_EN_ADDR, 8'hff);
    wr_byte(irqp::EXT_TWO_ADDR, 8'h07);
    do_reset();
    check_cleared();
    cmp_bit("ext0_flag_reset", 1'b0, xf0);
    wrap_up();
  end
endmodule
